// ==== src/lii_pkg.sv ====
// constants, types and shared helpers of the lcd instruction interface
package lii_pkg;
  // display data memory layout
  localparam logic [6:0] LII_ADDR_ZERO = 7'h00;
  localparam logic [6:0] LII_ADDR_ONE = 7'h01;
  localparam logic [6:0] LII_LINE2_BASE = 7'h40;
  localparam logic [6:0] LII_LINE1_LAST_2L = 7'h27;
  localparam logic [6:0] LII_LINE2_LAST = 7'h67;
  localparam logic [6:0] LII_LAST_1L = 7'h4F;
  localparam logic [6:0] LII_FILL_LAST = 7'h7F;
  localparam logic [7:0] LII_BLANK_CHAR = 8'h20;
  localparam logic [5:0] LII_CG_ONE = 6'h01;
  // serial slave address, upper six bits; the pin supplies the seventh
  localparam logic [5:0] LII_SLAVE_ADDR_HI = 6'h1D;
  localparam logic [3:0] LII_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LII_BIT_ONE = 4'h1;
  // instruction field positions
  localparam int LII_FS_DL = 4;
  localparam int LII_FS_N = 3;
  localparam int LII_DC_D = 2;
  localparam int LII_DC_C = 1;
  localparam int LII_DC_B = 0;
  localparam int LII_EM_ID = 1;
  localparam int LII_EM_S = 0;
  localparam int LII_SH_SC = 3;
  localparam int LII_SH_RL = 2;
  // control byte field positions
  localparam int LII_CB_CO = 7;
  localparam int LII_CB_RS = 6;
  localparam int LII_CB_RW = 5;

  typedef enum logic [3:0] {
    LII_OP_NONE, LII_OP_CLEAR, LII_OP_HOME, LII_OP_ENTRY, LII_OP_DISPCTL,
    LII_OP_SHIFT, LII_OP_FUNC, LII_OP_CGADDR, LII_OP_DDADDR
  } lii_op_type;

  // the highest set bit selects the instruction
  function automatic lii_op_type lii_decode(input logic [7:0] b);
    lii_op_type op;
    op = LII_OP_NONE;
    if (b[7]) op = LII_OP_DDADDR;
    else if (b[6]) op = LII_OP_CGADDR;
    else if (b[5]) op = LII_OP_FUNC;
    else if (b[4]) op = LII_OP_SHIFT;
    else if (b[3]) op = LII_OP_DISPCTL;
    else if (b[2]) op = LII_OP_ENTRY;
    else if (b[1]) op = LII_OP_HOME;
    else if (b[0]) op = LII_OP_CLEAR;
    return op;
  endfunction : lii_decode

  // next cursor address, wrapping across the line layout in use
  function automatic logic [6:0] lii_step_addr(input logic [6:0] a, input logic up, input logic two_line);
    logic [6:0] r;
    r = up ? a + LII_ADDR_ONE : a - LII_ADDR_ONE;
    if (two_line) begin
      if (up && a == LII_LINE1_LAST_2L) r = LII_LINE2_BASE;
      else if (up && a == LII_LINE2_LAST) r = LII_ADDR_ZERO;
      else if (!up && a == LII_LINE2_BASE) r = LII_LINE1_LAST_2L;
      else if (!up && a == LII_ADDR_ZERO) r = LII_LINE2_LAST;
    end else begin
      if (up && a == LII_LAST_1L) r = LII_ADDR_ZERO;
      else if (!up && a == LII_ADDR_ZERO) r = LII_LAST_1L;
    end
    return r;
  endfunction : lii_step_addr

  // pin filter: a change counts once the second and third stages agree
  function automatic logic lii_settle(input logic [2:0] s, input logic lvl);
    return (s[1] == s[2]) ? s[2] : lvl;
  endfunction : lii_settle
endpackage : lii_pkg

// ==== src/lii_cmd_if.sv ====
// one received byte with its instruction/data select, from a port to the interpreter
`timescale 1ns/1ps
`default_nettype none
interface lii_cmd_if;
  logic valid;
  logic rs;
  logic [7:0] data;
  modport src (output valid, output rs, output data);
  modport dst (input valid, input rs, input data);
endinterface : lii_cmd_if
`default_nettype wire

// ==== src/lii_par_port.sv ====
// parallel write port: latches the byte on the falling edge of the enable strobe
`timescale 1ns/1ps
`default_nettype none
module lii_par_port import lii_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins
  input wire logic par_enable,
  input wire logic instr_data_select,
  input wire logic par_read_write,
  input wire logic [7:0] parallel_data_bits,
  // to interpreter
  lii_cmd_if.src cmd
);
  typedef struct packed {
    logic [2:0] e_s;
    logic [2:0] rs_s;
    logic [2:0] rw_s;
    logic [2:0][7:0] d_s;
    logic e_lvl;
    logic valid;
    logic rs;
    logic [7:0] data;
  } lii_par_state_type;

  lii_par_state_type q, next_q;

  always_comb begin
    logic e_new;
    e_new = 1'b0;
    next_q = q;
    next_q.e_s = {q.e_s[1:0], par_enable};
    next_q.rs_s = {q.rs_s[1:0], instr_data_select};
    next_q.rw_s = {q.rw_s[1:0], par_read_write};
    next_q.d_s = {q.d_s[1:0], parallel_data_bits};
    e_new = lii_settle(q.e_s, q.e_lvl);
    next_q.e_lvl = e_new;
    next_q.valid = 1'b0;
    // reads are not served, only writes produce a byte
    if (q.e_lvl && !e_new && !q.rw_s[2]) begin
      next_q.valid = 1'b1;
      next_q.rs = q.rs_s[2];
      next_q.data = q.d_s[2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else q <= next_q;
  end

  assign cmd.valid = q.valid;
  assign cmd.rs = q.rs;
  assign cmd.data = q.data;

  property p_par_write_only;
    @(posedge core_clk) disable iff (!rst_n)
    q.valid |-> $past(!q.rw_s[2]) && (q.rs == $past(q.rs_s[2]));
  endproperty
  a_par_write_only: assert property (p_par_write_only) else $error("parallel byte taken without write strobe");
endmodule : lii_par_port
`default_nettype wire

// ==== src/lii_i2c_slave.sv ====
// serial write-only slave: address, control byte, data bytes, acknowledge
`timescale 1ns/1ps
`default_nettype none
module lii_i2c_slave import lii_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic slave_addr_select_pin,
  output logic sda_out,
  output logic sda_oe,
  // to interpreter
  lii_cmd_if.src cmd
);
  typedef enum logic [1:0] {LII_I2C_IDLE, LII_I2C_BITS, LII_I2C_ACK, LII_I2C_SKIP} lii_i2c_phase_type;
  typedef enum logic [1:0] {LII_KIND_ADDR, LII_KIND_CTRL, LII_KIND_DATA} lii_kind_type;
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] sa_s;
    logic scl;
    logic sda;
    lii_i2c_phase_type phase;
    lii_kind_type kind;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic control_continuation_bit;
    logic ctrl_rs;
    logic ctrl_rw;
    logic oe;
    logic valid;
    logic rs;
    logic [7:0] data;
  } lii_i2c_state_type;

  lii_i2c_state_type q, next_q;

  always_comb begin
    logic scl_n, sda_n, rise, fall;
    scl_n = lii_settle(q.scl_s, q.scl);
    sda_n = lii_settle(q.sda_s, q.sda);
    rise = !q.scl && scl_n;
    fall = q.scl && !scl_n;
    next_q = q;
    next_q.scl_s = {q.scl_s[1:0], scl_in};
    next_q.sda_s = {q.sda_s[1:0], sda_in};
    next_q.sa_s = {q.sa_s[1:0], slave_addr_select_pin};
    next_q.scl = scl_n;
    next_q.sda = sda_n;
    next_q.valid = 1'b0;
    if (q.scl && scl_n && q.sda && !sda_n) begin
      next_q.phase = LII_I2C_BITS;
      next_q.kind = LII_KIND_ADDR;
      next_q.bitcnt = '0;
      next_q.oe = 1'b0;
    end else if (q.scl && scl_n && !q.sda && sda_n) begin
      next_q.phase = LII_I2C_IDLE;
      next_q.oe = 1'b0;
    end else begin
      case (q.phase)
        LII_I2C_BITS: begin
          if (rise) begin
            next_q.shreg = {q.shreg[6:0], sda_n};
            next_q.bitcnt = q.bitcnt + LII_BIT_ONE;
          end else if (fall && q.bitcnt == LII_BITS_PER_BYTE) begin
            // only a write to our own address is acknowledged
            if (q.kind != LII_KIND_ADDR || q.shreg == {LII_SLAVE_ADDR_HI, q.sa_s[2], 1'b0}) begin
              next_q.phase = LII_I2C_ACK;
              next_q.oe = 1'b1;
            end else begin
              next_q.phase = LII_I2C_SKIP;
            end
          end
        end
        LII_I2C_ACK: begin
          if (rise) begin
            // execution starts on the clock pulse of the acknowledge
            if (q.kind == LII_KIND_CTRL) begin
              next_q.control_continuation_bit = q.shreg[LII_CB_CO];
              next_q.ctrl_rs = q.shreg[LII_CB_RS];
              next_q.ctrl_rw = q.shreg[LII_CB_RW];
            end else if (q.kind == LII_KIND_DATA && !q.ctrl_rw) begin
              next_q.valid = 1'b1;
              next_q.rs = q.ctrl_rs;
              next_q.data = q.shreg;
            end
          end else if (fall) begin
            next_q.oe = 1'b0;
            next_q.bitcnt = '0;
            next_q.phase = LII_I2C_BITS;
            if (q.kind == LII_KIND_ADDR) next_q.kind = LII_KIND_CTRL;
            else if (q.kind == LII_KIND_CTRL) next_q.kind = LII_KIND_DATA;
            else next_q.kind = q.control_continuation_bit ? LII_KIND_CTRL : LII_KIND_DATA;
          end
        end
        default: ;
      endcase
    end
  end

  // lines idle high; filters cleared to low would show a false rise on release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = q.oe;
  assign cmd.valid = q.valid;
  assign cmd.rs = q.rs;
  assign cmd.data = q.data;

  property p_exec_on_ack;
    @(posedge core_clk) disable iff (!rst_n)
    q.valid |-> $past(q.phase) == LII_I2C_ACK && q.scl && !$past(q.scl);
  endproperty
  a_exec_on_ack: assert property (p_exec_on_ack) else $error("serial byte executed outside its acknowledge pulse");

  property p_ack_drive;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(q.oe) |-> q.phase == LII_I2C_ACK && q.bitcnt == LII_BITS_PER_BYTE && !q.scl;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("data line pulled outside acknowledge");
endmodule : lii_i2c_slave
`default_nettype wire

// ==== src/lcd_instruction_interface.sv ====
// instruction interpreter of a character display controller, parallel and serial host ports
`timescale 1ns/1ps
`default_nettype none
module lcd_instruction_interface import lii_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // parallel host port
  input wire logic par_enable,
  input wire logic instr_data_select,
  input wire logic par_read_write,
  input wire logic [7:0] parallel_data_bits,
  // serial host port
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic slave_addr_select_pin,
  output logic sda_out,
  output logic sda_oe,
  // configuration and status
  output logic busy,
  output logic display_on,
  output logic cursor_on,
  output logic blink_on,
  output logic two_line,
  output logic data_8bit,
  output logic addr_increment,
  output logic shift_on_write,
  output logic [6:0] cursor_addr,
  output logic [5:0] cg_addr,
  output logic [6:0] display_shift,
  // memory write port
  output logic ram_we,
  output logic ram_cg_sel,
  output logic [6:0] ram_addr,
  output logic [7:0] ram_wdata
);
  typedef enum logic [1:0] {LII_PH_FILL, LII_PH_RUN} lii_phase_type;
  typedef struct packed {
    lii_phase_type phase;
    logic [6:0] fill_addr;
    logic [6:0] dd_addr;
    logic [5:0] cg_addr;
    logic sel_cg;
    logic disp_on;
    logic cur_on;
    logic blink;
    logic lines2;
    logic dl8;
    logic inc;
    logic shift;
    logic [6:0] dshift;
    logic we;
    logic we_cg;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic busy;
  } lii_top_state_type;

  logic [1:0] rst_sync;
  logic rst_n;
  lii_top_state_type q, next_q;
  logic cmd_valid;
  logic cmd_rs;
  logic [7:0] cmd_data;
  lii_op_type op;

  // reset is released through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rst_sync <= '0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  lii_cmd_if par_cmd ();
  lii_cmd_if ser_cmd ();

  lii_par_port u_par (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .par_enable(par_enable),
    .instr_data_select(instr_data_select),
    .par_read_write(par_read_write),
    .parallel_data_bits(parallel_data_bits),
    .cmd(par_cmd.src)
  );

  lii_i2c_slave u_ser (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .slave_addr_select_pin(slave_addr_select_pin),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .cmd(ser_cmd.src)
  );

  // one host port is in use at a time; on a clash the parallel byte wins
  always_comb begin
    cmd_valid = par_cmd.valid | ser_cmd.valid;
    cmd_rs = par_cmd.valid ? par_cmd.rs : ser_cmd.rs;
    cmd_data = par_cmd.valid ? par_cmd.data : ser_cmd.data;
  end
  assign op = lii_decode(cmd_data);

  always_comb begin
    next_q = q;
    next_q.we = 1'b0;
    case (q.phase)
      LII_PH_FILL: begin
        // blank every display data location, not the character generator memory; bytes arriving now are dropped, busy shows it
        next_q.we = 1'b1;
        next_q.we_cg = 1'b0;
        next_q.waddr = q.fill_addr;
        next_q.wdata = LII_BLANK_CHAR;
        next_q.fill_addr = q.fill_addr + LII_ADDR_ONE;
        if (q.fill_addr == LII_FILL_LAST) next_q.phase = LII_PH_RUN;
      end
      LII_PH_RUN: begin
        if (cmd_valid && cmd_rs) begin
          next_q.we = 1'b1;
          next_q.we_cg = q.sel_cg;
          next_q.wdata = cmd_data;
          if (q.sel_cg) begin
            next_q.waddr = {1'b0, q.cg_addr};
            next_q.cg_addr = q.inc ? q.cg_addr + LII_CG_ONE : q.cg_addr - LII_CG_ONE;
          end else begin
            next_q.waddr = q.dd_addr;
            next_q.dd_addr = lii_step_addr(q.dd_addr, q.inc, q.lines2);
            if (q.shift) begin
              // one shift count for the whole display, so both lines move together
              next_q.dshift = q.inc ? q.dshift + LII_ADDR_ONE : q.dshift - LII_ADDR_ONE;
            end
          end
        end else if (cmd_valid) begin
          case (op)
            LII_OP_CLEAR: begin
              next_q.phase = LII_PH_FILL;
              next_q.fill_addr = LII_ADDR_ZERO;
              next_q.dd_addr = LII_ADDR_ZERO;
              next_q.dshift = LII_ADDR_ZERO;
              next_q.sel_cg = 1'b0;
              next_q.inc = 1'b1;
            end
            LII_OP_HOME: begin
              next_q.dd_addr = LII_ADDR_ZERO;
              next_q.dshift = LII_ADDR_ZERO;
              next_q.sel_cg = 1'b0;
            end
            LII_OP_ENTRY: begin
              next_q.inc = cmd_data[LII_EM_ID];
              next_q.shift = cmd_data[LII_EM_S];
            end
            LII_OP_DISPCTL: begin
              next_q.disp_on = cmd_data[LII_DC_D];
              next_q.cur_on = cmd_data[LII_DC_C];
              next_q.blink = cmd_data[LII_DC_B];
            end
            LII_OP_SHIFT: begin
              if (cmd_data[LII_SH_SC]) begin
                next_q.dshift = cmd_data[LII_SH_RL] ? q.dshift - LII_ADDR_ONE : q.dshift + LII_ADDR_ONE;
              end else begin
                next_q.dd_addr = lii_step_addr(q.dd_addr, cmd_data[LII_SH_RL], q.lines2);
              end
            end
            LII_OP_FUNC: begin
              next_q.dl8 = cmd_data[LII_FS_DL];
              next_q.lines2 = cmd_data[LII_FS_N];
            end
            LII_OP_CGADDR: begin
              next_q.cg_addr = cmd_data[5:0];
              next_q.sel_cg = 1'b1;
            end
            LII_OP_DDADDR: begin
              next_q.dd_addr = cmd_data[6:0];
              next_q.sel_cg = 1'b0;
            end
            default: ;
          endcase
        end
      end
      default: next_q.phase = LII_PH_RUN;
    endcase
    // busy has its own flop so the port is registered, not decoded from the phase
    next_q.busy = (next_q.phase == LII_PH_FILL);
  end

  // reset: fill phase, display off, display memory selected, 8-bit, increment
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.phase <= LII_PH_FILL;
      q.busy <= 1'b1;
      q.dl8 <= 1'b1;
      q.inc <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign busy = q.busy;
  assign display_on = q.disp_on;
  assign cursor_on = q.cur_on;
  assign blink_on = q.blink;
  assign two_line = q.lines2;
  assign data_8bit = q.dl8;
  assign addr_increment = q.inc;
  assign shift_on_write = q.shift;
  assign cursor_addr = q.dd_addr;
  assign cg_addr = q.cg_addr;
  assign display_shift = q.dshift;
  assign ram_we = q.we;
  assign ram_cg_sel = q.we_cg;
  assign ram_addr = q.waddr;
  assign ram_wdata = q.wdata;

  property p_reset_blank;
    @(posedge core_clk)
    $rose(rst_n) |-> busy && !display_on && !ram_cg_sel && cursor_addr == LII_ADDR_ZERO;
  endproperty
  a_reset_blank: assert property (p_reset_blank) else $error("reset state not blank");

  property p_fill_blank;
    @(posedge core_clk) disable iff (!rst_n)
    busy |=> ram_we && ram_wdata == LII_BLANK_CHAR && !ram_cg_sel;
  endproperty
  a_fill_blank: assert property (p_fill_blank) else $error("fill does not write blank code");

  property p_func_set;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && !cmd_rs && op == LII_OP_FUNC) |=>
      two_line == $past(cmd_data[LII_FS_N]) && data_8bit == $past(cmd_data[LII_FS_DL]);
  endproperty
  a_func_set: assert property (p_func_set) else $error("function set not applied");

  property p_single_line;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && !cmd_rs && {cmd_data[7:5], cmd_data[3:0]} == 7'h10) |=> !two_line;
  endproperty
  a_single_line: assert property (p_single_line) else $error("single line not selected");

  property p_disp_ctl;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && !cmd_rs && cmd_data == 8'h0E) |=> display_on && cursor_on && !blink_on;
  endproperty
  a_disp_ctl: assert property (p_disp_ctl) else $error("display control not applied");

  property p_entry_mode;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && !cmd_rs && cmd_data == 8'h06) |=> addr_increment && !shift_on_write;
  endproperty
  a_entry_mode: assert property (p_entry_mode) else $error("entry mode not applied");

  property p_data_write;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && cmd_rs && !q.sel_cg) |=>
      ram_we && ram_addr == $past(cursor_addr) && ram_wdata == $past(cmd_data)
      && cursor_addr == lii_step_addr($past(cursor_addr), $past(addr_increment), two_line);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write misplaced or cursor not moved");

  property p_set_addr;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && !cmd_rs && cmd_data[7]) |=> cursor_addr == $past(cmd_data[6:0]) && !ram_we;
  endproperty
  a_set_addr: assert property (p_set_addr) else $error("address not loaded");

  property p_shift_write;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && cmd_rs && !q.sel_cg && shift_on_write && addr_increment) |=>
      display_shift == $past(display_shift) + LII_ADDR_ONE;
  endproperty
  a_shift_write: assert property (p_shift_write) else $error("display not shifted left on write");

  property p_home;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && !cmd_rs && op == LII_OP_HOME) |=>
      cursor_addr == LII_ADDR_ZERO && display_shift == LII_ADDR_ZERO ##1 !ram_we;
  endproperty
  a_home: assert property (p_home) else $error("return home incomplete");

  property p_entry_shift;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && !cmd_rs && cmd_data == 8'h07) |=> addr_increment && shift_on_write;
  endproperty
  a_entry_shift: assert property (p_entry_shift) else $error("entry mode with shift not applied");

  property p_instr_no_store;
    @(posedge core_clk) disable iff (!rst_n)
    (!busy && cmd_valid && !cmd_rs) |=> !ram_we;
  endproperty
  a_instr_no_store: assert property (p_instr_no_store) else $error("instruction byte stored as data");
endmodule : lcd_instruction_interface
`default_nettype wire

// ==== bench/lii_host.sv ====
// host model driving the parallel and serial ports
`timescale 1ns/1ps
`default_nettype none
module lii_host (
  // clock
  input wire logic core_clk,
  // parallel pins
  output logic par_enable,
  output logic instr_data_select,
  output logic par_read_write,
  output logic [7:0] parallel_data_bits,
  // serial pins
  output logic scl_in,
  output logic sda_in,
  input wire logic sda_oe
);
  logic sda_drv;
  // data line has a pull-up; the device only pulls low
  assign sda_in = sda_drv & ~sda_oe;
  initial begin
    sda_drv = 1'b1;
    scl_in = 1'b1;
    par_enable = 1'b0;
    instr_data_select = 1'b0;
    par_read_write = 1'b0;
    parallel_data_bits = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // pins settle well before and after the strobe fall
  task automatic par_write(input logic rs, input logic [7:0] d);
    instr_data_select = rs;
    par_read_write = 1'b0;
    parallel_data_bits = d;
    cyc(6);
    par_enable = 1'b1;
    cyc(6);
    par_enable = 1'b0;
    cyc(12);
  endtask : par_write
  task automatic i2c_start();
    sda_drv = 1'b1;
    scl_in = 1'b1;
    cyc(6);
    sda_drv = 1'b0;
    cyc(6);
    scl_in = 1'b0;
    cyc(4);
  endtask : i2c_start
  // control bytes and data bytes go through here alike
  task automatic i2c_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = d[i];
      cyc(6);
      scl_in = 1'b1;
      cyc(6);
      scl_in = 1'b0;
      cyc(4);
    end
    sda_drv = 1'b1;
    cyc(6);
    scl_in = 1'b1;
    cyc(3);
    ack = ~sda_in;
    cyc(3);
    scl_in = 1'b0;
    cyc(4);
  endtask : i2c_byte
  task automatic i2c_stop();
    sda_drv = 1'b0;
    cyc(6);
    scl_in = 1'b1;
    cyc(6);
    sda_drv = 1'b1;
    cyc(6);
  endtask : i2c_stop
endmodule : lii_host
`default_nettype wire

// ==== bench/lcd_instruction_interface_tb.sv ====
// self-checking bench of the instruction interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module lcd_instruction_interface_tb;
  import lii_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  wire logic pe, rs, rw, scl, sda, oe, busy, don, con, tl, d8, inc, we, sdo, bl, sow, cgs;
  wire logic [7:0] pd, wd;
  wire logic [6:0] ca, sh, ra;
  wire logic [5:0] cga;
  logic [6:0] last_addr = 7'h00;
  logic [7:0] last_data = 8'h00;
  logic last_cg = 1'b0;
  logic ack;
  int err_count = 0;
  int compares = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (we) begin
    last_addr <= ra;
    last_data <= wd;
    last_cg <= cgs;
  end
  lii_host i_lii_host (.core_clk(core_clk), .par_enable(pe), .instr_data_select(rs),
    .par_read_write(rw), .parallel_data_bits(pd), .scl_in(scl), .sda_in(sda), .sda_oe(oe));
  lcd_instruction_interface i_lcd_instruction_interface (.core_clk(core_clk),
    .reset_n(reset_n), .par_enable(pe), .instr_data_select(rs), .par_read_write(rw),
    .parallel_data_bits(pd), .scl_in(scl), .sda_in(sda), .slave_addr_select_pin(1'b0),
    .sda_out(sdo), .sda_oe(oe), .busy(busy), .display_on(don), .cursor_on(con),
    .blink_on(bl), .two_line(tl), .data_8bit(d8), .addr_increment(inc),
    .shift_on_write(sow), .cursor_addr(ca), .cg_addr(cga), .display_shift(sh), .ram_we(we),
    .ram_cg_sel(cgs), .ram_addr(ra), .ram_wdata(wd));
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic t_reset();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge core_clk);
    #1;
    `CHK("busy", 1'b0, busy)
    `CHK("blank", LII_BLANK_CHAR, last_data)
    `CHK("blank_end", LII_FILL_LAST, last_addr)
    `CHK("blank_dd", 1'b0, last_cg)
    `CHK("disp_off", 1'b0, don)
    `CHK("cg_idle", 6'h00, cga)
  endtask : t_reset
  task automatic t_par();
    i_lii_host.par_write(1'b0, 8'h28);
    `CHK("narrow", 1'b0, d8)
    i_lii_host.par_write(1'b0, 8'h38);
    `CHK("two_line", 1'b1, tl)
    `CHK("width", 1'b1, d8)
    i_lii_host.par_write(1'b0, 8'h0E);
    `CHK("disp", 3'h6, {don, con, bl})
    i_lii_host.par_write(1'b0, 8'h06);
    `CHK("entry", 2'h2, {inc, sow})
    i_lii_host.par_write(1'b1, 8'h50);
    `CHK("waddr", LII_ADDR_ZERO, last_addr)
    `CHK("wdata", 8'h50, last_data)
    `CHK("wdd", 1'b0, last_cg)
    `CHK("cur", LII_ADDR_ONE, ca)
    `CHK("noshift", 7'h00, sh)
    i_lii_host.par_write(1'b0, 8'hC0);
    `CHK("setaddr", LII_LINE2_BASE, ca)
    i_lii_host.par_write(1'b0, 8'h07);
    `CHK("shift_on", 1'b1, sow)
    i_lii_host.par_write(1'b1, 8'h4D);
    `CHK("saddr", LII_LINE2_BASE, last_addr)
    `CHK("shift", 7'h01, sh)
    i_lii_host.par_write(1'b0, 8'h02);
    `CHK("home", LII_ADDR_ZERO, ca)
    `CHK("unshift", 7'h00, sh)
  endtask : t_par
  task automatic t_i2c();
    i_lii_host.i2c_start();
    i_lii_host.i2c_byte({LII_SLAVE_ADDR_HI, 2'b00}, ack);
    `CHK("addr_ack", 1'b1, ack)
    `CHK("sda_lvl", 1'b0, sdo)
    i_lii_host.i2c_byte(8'h00, ack);
    `CHK("ctl_ack", 1'b1, ack)
    i_lii_host.i2c_byte(8'h30, ack);
    `CHK("one_line", 1'b0, tl)
    i_lii_host.i2c_stop();
    i_lii_host.i2c_start();
    i_lii_host.i2c_byte({LII_SLAVE_ADDR_HI, 2'b00}, ack);
    i_lii_host.i2c_byte(8'h40, ack);
    i_lii_host.i2c_byte(8'h48, ack);
    `CHK("sdata", 8'h48, last_data)
    `CHK("scur", LII_ADDR_ONE, ca)
    i_lii_host.i2c_stop();
    i_lii_host.i2c_start();
    i_lii_host.i2c_byte({LII_SLAVE_ADDR_HI, 2'b10}, ack);
    `CHK("other_nak", 1'b0, ack)
    i_lii_host.i2c_stop();
  endtask : t_i2c
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_par();
    t_i2c();
    report_and_stop();
  end
  // all scenarios need about 1500 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end
endmodule : lcd_instruction_interface_tb
`default_nettype wire
